/* File: pkg/swe_pkg.sv */
// Functional notes
// - Literal subtract computes immediate minus accumulator in 8 bits.
// - Literal subtract always writes its difference into the accumulator.
// - Literal subtract: one word, decode, read literal, process, write accumulator.
// - Register subtract computes addressed register minus accumulator, two's complement.
// - Target bit 0 writes accumulator; 1 writes result back to the register.
// - Common-region bit 0 uses access bank; 1 uses bank pointer register.
// - Extended set, common bit 0, operand at most 95: indexed literal offset.
// - Register subtract: one word, decode, read register, process, write target.
// - Carry clear on negative result, set on zero or positive result.
// - Zero flag set when difference is zero; sign flag is bit 7.
package swe_pkg;
   // Register byte offsets
   localparam logic [4:0] OFS_CTRL = 5'h00;
   localparam logic [4:0] OFS_INSTR = 5'h04;
   localparam logic [4:0] OFS_ACC = 5'h08;
   localparam logic [4:0] OFS_BANK = 5'h0c;
   localparam logic [4:0] OFS_IDX = 5'h10;
   localparam logic [4:0] OFS_STAT = 5'h14;
   localparam logic [4:0] OFS_RES = 5'h18;
   localparam int ADDR_W = 5;
   // Status field positions
   localparam int ST_C = 0;
   localparam int ST_NIB = 1;
   localparam int ST_Z = 2;
   localparam int ST_WRAP = 3;
   localparam int ST_N = 4;
   localparam int ST_BUSY = 5;
   localparam int ST_ILL = 6;
   // Control field positions
   localparam int CT_EXT = 0;
   // Instruction fields
   localparam logic [7:0] OPC_LIT = 8'h08;
   localparam logic [5:0] OPC_REG_DEF = 6'h17;
   localparam int IN_D = 9;
   localparam int IN_A = 8;
   localparam logic [7:0] IDX_LIMIT = 8'h5f;
   localparam logic [3:0] ACC_BANK_HI = 4'hf;
   localparam logic [3:0] ACC_BANK_LO = 4'h0;
   // Reset values
   localparam logic [7:0] RST_ACC = 8'h00;
   localparam logic [3:0] RST_BANK = 4'h0;
   localparam logic [11:0] RST_IDX = 12'h000;
   localparam logic [15:0] RST_INSTR = 16'h0000;
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // Instruction phases
   typedef enum logic [2:0] {
      PH_IDLE, PH_DECODE, PH_READ, PH_PROC, PH_WRITE
   } swe_phase_t;
endpackage : swe_pkg

/* File: core/swe_exec_unit.sv */
`timescale 1ns/10ps
module swe_exec_unit
   import swe_pkg::*;
#(
   parameter int MEM_AW = 12,
   parameter logic [5:0] REG_OPC = OPC_REG_DEF
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [MEM_AW-1:0] memAddr,
   input wire logic [7:0] memRdata,
   output logic memWe,
   output logic [7:0] memWdata
);

   // Parameter sanity
   if (MEM_AW != 12) begin : g_chk
      $error("swe_exec_unit: MEM_AW must be 12");
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);

   swe_phase_t phase;
   logic awHeld, wHeld;
   logic [ADDR_W-1:0] awAddr;
   logic [31:0] wData;
   logic [3:0] wStrb;
   logic wrFire, wrMapped;
   logic extEn;
   logic [3:0] bankPtr;
   logic [11:0] idxBase;
   logic [7:0] acc;
   logic [15:0] instr;
   logic startReq;
   logic opIsReg, destAcc, illegal;
   logic [7:0] operand, result;
   logic flagC, flagNib, flagZ, flagWrap, flagN;
   logic isLit, isReg, useIdx;
   logic [11:0] next_memAddr;
   logic [31:0] mergedW, mergedIdx, readMux;
   logic rdMapped;
   logic [8:0] diffFull;
   logic [4:0] diffLow;
   logic [7:0] diff;

   // Byte-lane merge of write data
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = dat[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   // Write channel handshakes
   assign s_axi_awready = !awHeld && !s_axi_bvalid;
   assign s_axi_wready = !wHeld && !s_axi_bvalid;
   assign wrFire = awHeld && wHeld && !s_axi_bvalid;

   // Address and data capture, either order
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awAddr <= '0;
         wData <= '0;
         wStrb <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr[ADDR_W-1:0];
         end else if (wrFire) begin
            awHeld <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
         end else if (wrFire) begin
            wHeld <= 1'b0;
         end
      end
   end

   // Writable offsets
   always_comb begin
      unique case (awAddr)
         OFS_CTRL, OFS_INSTR, OFS_ACC, OFS_BANK, OFS_IDX: wrMapped = 1'b1;
         default: wrMapped = 1'b0;
      endcase
   end

   // Write response
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wrFire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   assign mergedW = merge(32'h0000_0000, wData, wStrb);
   // Index base keeps the lanes that are not strobed
   assign mergedIdx = merge({20'h0, idxBase}, wData, wStrb);

   // Configuration registers
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         extEn <= 1'b0;
         bankPtr <= RST_BANK;
         idxBase <= RST_IDX;
      end else if (wrFire) begin
         if (awAddr == OFS_CTRL && wStrb[0]) extEn <= mergedW[CT_EXT];
         if (awAddr == OFS_BANK && wStrb[0]) bankPtr <= mergedW[3:0];
         if (awAddr == OFS_IDX) idxBase <= mergedIdx[11:0];
      end
   end

   // Instruction issue, only while idle
   assign startReq = wrFire && awAddr == OFS_INSTR && phase == PH_IDLE;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         instr <= RST_INSTR;
      end else if (startReq) begin
         instr <= mergedW[15:0];
      end
   end

   // Opcode decode
   assign isLit = instr[15:8] == OPC_LIT;
   assign isReg = instr[15:10] == REG_OPC;
   assign useIdx = extEn && !instr[IN_A] && instr[7:0] <= IDX_LIMIT;

   // Operand address resolution
   always_comb begin
      if (useIdx) begin
         next_memAddr = idxBase + {4'h0, instr[7:0]};
      end else if (!instr[IN_A]) begin
         next_memAddr = {instr[7] ? ACC_BANK_HI : ACC_BANK_LO, instr[7:0]};
      end else begin
         next_memAddr = {bankPtr, instr[7:0]};
      end
   end

   // Four-phase sequencer
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         phase <= PH_IDLE;
      end else begin
         unique case (phase)
            PH_IDLE: if (startReq) phase <= PH_DECODE;
            PH_DECODE: phase <= (isLit || isReg) ? PH_READ : PH_IDLE;
            PH_READ: phase <= PH_PROC;
            PH_PROC: phase <= PH_WRITE;
            PH_WRITE: phase <= PH_IDLE;
         endcase
      end
   end

   // Decode results held for the instruction
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         opIsReg <= 1'b0;
         destAcc <= 1'b1;
         illegal <= 1'b0;
         memAddr <= '0;
      end else if (startReq) begin
         illegal <= 1'b0;
      end else if (phase == PH_DECODE) begin
         opIsReg <= isReg;
         destAcc <= isLit || !instr[IN_D];
         illegal <= !(isLit || isReg);
         if (isReg) memAddr <= next_memAddr;
      end
   end

   // Operand fetch
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         operand <= 8'h00;
      end else if (phase == PH_READ) begin
         operand <= opIsReg ? memRdata : instr[7:0];
      end
   end

   // Subtraction with borrow chains
   assign diffFull = {1'b0, operand} - {1'b0, acc};
   assign diffLow = {1'b0, operand[3:0]} - {1'b0, acc[3:0]};
   assign diff = diffFull[7:0];

   // Result and flag update
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         result <= 8'h00;
         flagC <= 1'b0;
         flagNib <= 1'b0;
         flagZ <= 1'b0;
         flagWrap <= 1'b0;
         flagN <= 1'b0;
      end else if (phase == PH_PROC) begin
         result <= diff;
         flagC <= !diffFull[8];
         flagNib <= !diffLow[4];
         flagZ <= diff == 8'h00;
         flagN <= diff[7];
         flagWrap <= (operand[7] != acc[7]) && (diff[7] != operand[7]);
      end
   end

   // Accumulator, instruction wins, software only while idle
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         acc <= RST_ACC;
      end else if (phase == PH_WRITE && destAcc) begin
         acc <= result;
      end else if (wrFire && awAddr == OFS_ACC && phase == PH_IDLE && wStrb[0]) begin
         acc <= mergedW[7:0];
      end
   end

   // Register write-back
   assign memWe = phase == PH_WRITE && opIsReg && !destAcc;
   assign memWdata = result;

   // Read data mux
   always_comb begin
      rdMapped = 1'b1;
      unique case (s_axi_araddr[ADDR_W-1:0])
         OFS_CTRL: readMux = {31'h0, extEn};
         OFS_INSTR: readMux = {16'h0, instr};
         OFS_ACC: readMux = {24'h0, acc};
         OFS_BANK: readMux = {28'h0, bankPtr};
         OFS_IDX: readMux = {20'h0, idxBase};
         OFS_STAT: readMux = {25'h0, illegal, phase != PH_IDLE, flagN, flagWrap, flagZ,
                              flagNib, flagC};
         OFS_RES: readMux = {24'h0, result};
         default: begin
            readMux = 32'h0000_0000;
            rdMapped = 1'b0;
         end
      endcase
   end

   assign s_axi_arready = !s_axi_rvalid;

   // Read response
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= readMux;
         s_axi_rresp <= rdMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Checks on the datapath
   a_lit_operand: assert property (phase == PH_READ && !opIsReg
      |=> operand == $past(instr[7:0]))
      else $error("literal operand not taken");

   a_lit_to_acc: assert property (phase == PH_WRITE && !opIsReg
      |=> acc == $past(result) && !$past(memWe))
      else $error("literal result not in accumulator");

   a_phase_order: assert property (phase == PH_DECODE && (isLit || isReg)
      |=> phase == PH_READ ##1 phase == PH_PROC ##1 phase == PH_WRITE
      ##1 phase == PH_IDLE)
      else $error("phase sequence broken");

   a_reg_operand: assert property (phase == PH_READ && opIsReg
      |=> operand == $past(memRdata))
      else $error("register operand not taken");

   a_sub_value: assert property (phase == PH_PROC
      |=> result == 8'($past(operand) - $past(acc)))
      else $error("difference wrong");

   // Target taken from the instruction word itself, not from the decode register
   a_dest_select: assert property (phase == PH_WRITE
      |-> memWe == (opIsReg && instr[IN_D]))
      else $error("destination select wrong");

   a_access_bank: assert property (phase == PH_DECODE && isReg && !instr[IN_A]
      && !useIdx |=> memAddr == {$past(instr[7]) ? ACC_BANK_HI : ACC_BANK_LO,
      $past(instr[7:0])})
      else $error("access bank address wrong");

   a_bank_ptr: assert property (phase == PH_DECODE && isReg && instr[IN_A]
      |=> memAddr == {$past(bankPtr), $past(instr[7:0])})
      else $error("banked address wrong");

   a_indexed_addr: assert property (phase == PH_DECODE && isReg && useIdx
      |=> memAddr == 12'($past(idxBase) + $past(instr[7:0])))
      else $error("indexed address wrong");

   a_borrow_flag: assert property (phase == PH_PROC
      |=> flagC == ($past(operand) >= $past(acc)))
      else $error("carry flag wrong");

   a_zero_sign: assert property (phase == PH_PROC
      |=> flagZ == (result == 8'h00) && flagN == result[7])
      else $error("zero or sign flag wrong");

   a_nibble_flag: assert property (phase == PH_PROC
      |=> flagNib == ($past(operand[3:0]) >= $past(acc[3:0])))
      else $error("nibble flag wrong");

   a_wrap_flag: assert property (phase == PH_PROC
      |=> flagWrap == ($past(operand[7]) != $past(acc[7])
      && result[7] != $past(operand[7])))
      else $error("overflow flag wrong");

   // Main scenarios
   c_lit_done: cover property (phase == PH_WRITE && !opIsReg);
   c_reg_to_mem: cover property (memWe);
   c_reg_to_acc: cover property (phase == PH_WRITE && opIsReg && destAcc);
   c_negative: cover property (phase == PH_PROC ##1 !flagC);
   c_indexed: cover property (phase == PH_DECODE && isReg && useIdx);

endmodule : swe_exec_unit

/* File: verif/swe_mem_model.sv */
`timescale 1ns/10ps
// Byte-wide data memory on the far side of the execution unit
module swe_mem_model (
   input wire logic clk_sys,
   input wire logic [11:0] memAddr,
   output logic [7:0] memRdata,
   input wire logic memWe,
   input wire logic [7:0] memWdata
);
   logic [7:0] store [4096];
   // Combinational read, answered in the same cycle
   assign memRdata = store[memAddr];
   // Write-back at the end of the write phase
   always @(posedge clk_sys) begin
      if (memWe) begin
         store[memAddr] <= memWdata;
      end
   end
endmodule : swe_mem_model

/* File: verif/tb.sv */
`timescale 1ns/10ps
`define CHK(g, e) begin checksDone++; if ((g) !== (e)) begin fails++; $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
   import swe_pkg::*;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic [31:0] awaddr = '0;
   logic [31:0] wdata = '0;
   logic [31:0] araddr = '0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic arvalid = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, memWe;
   logic [1:0] bresp, rresp, rsp;
   logic [31:0] rdata, rd;
   logic [11:0] memAddr;
   logic [7:0] memRdata, memWdata, expDiff;
   logic [6:0] expSt;
   int fails = 0;
   int checksDone = 0;
   int cycles = 0;
   int weCount = 0;
   int weCycle = 0;
   int bCycle = 0;

   swe_exec_unit dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(1'b1), .memAddr(memAddr), .memRdata(memRdata), .memWe(memWe),
      .memWdata(memWdata));
   swe_mem_model mem (.clk_sys(clk_sys), .memAddr(memAddr), .memRdata(memRdata),
      .memWe(memWe), .memWdata(memWdata));

   // Clock generation
   initial begin
      forever #20 clk_sys = ~clk_sys;
   end

   // Cycle count, write-pulse monitor and hang guard
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (memWe === 1'b1) begin
         weCount <= weCount + 1;
         weCycle <= cycles;
      end
      if (cycles == 5000) begin
         fails++;
         end_sim();
      end
   end

   task automatic end_sim;
      $display("checks %0d mismatches %0d", checksDone, fails);
      if (fails == 0 && checksDone > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_sim

   // Write with address and data offered together
   task automatic axiWrite(input logic [4:0] a, input logic [15:0] d);
      logic awDone;
      logic wDone;
      awDone = 1'b0;
      wDone = 1'b0;
      awaddr <= {27'h0, a};
      wdata <= {16'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (!awDone && awready) begin
            awDone = 1'b1;
            awvalid <= 1'b0;
         end
         if (!wDone && wready) begin
            wDone = 1'b1;
            wvalid <= 1'b0;
         end
      end while (!(awDone && wDone));
      do @(posedge clk_sys); while (bvalid !== 1'b1);
      bCycle = cycles;
      rsp = bresp;
   endtask : axiWrite

   task automatic axiRead(input logic [4:0] a);
      araddr <= {27'h0, a};
      arvalid <= 1'b1;
      do @(posedge clk_sys); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk_sys); while (rvalid !== 1'b1);
      rd = rdata;
      rsp = rresp;
   endtask : axiRead

   // Poll status until the operation has retired
   task automatic waitIdle;
      do axiRead(OFS_STAT); while (rd[ST_BUSY] !== 1'b0);
   endtask : waitIdle

   // Expected difference and flags of minuend m minus w
   task automatic calc(input logic [7:0] m, input logic [7:0] w);
      expDiff = m - w;
      expSt = '0;
      expSt[ST_C] = m >= w;
      expSt[ST_NIB] = m[3:0] >= w[3:0];
      expSt[ST_Z] = expDiff == 8'h00;
      expSt[ST_WRAP] = (m[7] != w[7]) && (expDiff[7] != m[7]);
      expSt[ST_N] = expDiff[7];
   endtask : calc

   task automatic litCase(input logic [7:0] w, input logic [7:0] k);
      int n;
      calc(k, w);
      n = weCount;
      axiWrite(OFS_ACC, {8'h0, w});
      axiWrite(OFS_INSTR, {OPC_LIT, k});
      `CHK(rsp, RESP_OKAY)
      waitIdle();
      `CHK(rd[6:0], expSt)
      axiRead(OFS_ACC);
      `CHK(rd[7:0], expDiff)
      `CHK(weCount, n)
   endtask : litCase

   task automatic regCase(input logic ext, input logic [3:0] bank, input logic d,
         input logic a, input logic [7:0] f, input logic [11:0] ea,
         input logic [7:0] m, input logic [7:0] w);
      int n;
      int b;
      calc(m, w);
      n = weCount;
      axiWrite(OFS_CTRL, {15'h0, ext});
      axiWrite(OFS_BANK, {12'h0, bank});
      axiWrite(OFS_ACC, {8'h0, w});
      mem.store[ea] = m;
      axiWrite(OFS_INSTR, {OPC_REG_DEF, d, a, f});
      b = bCycle;
      waitIdle();
      `CHK(rd[6:0], expSt)
      `CHK(memAddr, ea)
      axiRead(OFS_RES);
      `CHK(rd[7:0], expDiff)
      axiRead(OFS_ACC);
      if (d) begin
         `CHK(mem.store[ea], expDiff)
         `CHK(rd[7:0], w)
         `CHK(weCycle - b, 3)
      end else begin
         `CHK(mem.store[ea], m)
         `CHK(rd[7:0], expDiff)
         `CHK(weCount, n)
      end
   endtask : regCase

   // Main sequence
   initial begin
      repeat (16) @(posedge clk_sys);
      sys_rst <= 1'b0;
      axiRead(OFS_STAT);
      `CHK(rd, 32'h0)
      axiRead(OFS_ACC);
      `CHK(rd, 32'h0)
      `CHK(rsp, RESP_OKAY)
      litCase(8'h01, 8'h02);
      litCase(8'h02, 8'h02);
      litCase(8'h03, 8'h02);
      litCase(8'h80, 8'h01);
      litCase(8'h0f, 8'h10);
      axiWrite(OFS_IDX, 16'h0300);
      regCase(1'b0, 4'h2, 1'b1, 1'b1, 8'h10, 12'h210, 8'h03, 8'h02);
      regCase(1'b0, 4'h5, 1'b0, 1'b0, 8'h90, 12'hf90, 8'h02, 8'h02);
      regCase(1'b0, 4'h5, 1'b1, 1'b0, 8'h20, 12'h020, 8'h01, 8'h02);
      regCase(1'b1, 4'h5, 1'b1, 1'b0, 8'h5f, 12'h35f, 8'h7f, 8'h80);
      regCase(1'b1, 4'h5, 1'b1, 1'b0, 8'h60, 12'h060, 8'h40, 8'h11);
      regCase(1'b1, 4'h7, 1'b0, 1'b1, 8'h20, 12'h720, 8'h00, 8'h01);
      axiWrite(OFS_INSTR, 16'hffff);
      waitIdle();
      `CHK(rd[ST_ILL], 1'b1)
      axiWrite(OFS_STAT, 16'h0001);
      `CHK(rsp, RESP_SLVERR)
      axiRead(5'h1c);
      `CHK(rsp, RESP_SLVERR)
      end_sim();
   end
endmodule : tb
